/* File: inc/ssr_defines.svh */
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SSR_OFF_BAUD_CTRL  8'h00
`define SSR_OFF_RX_CTRL    8'h04
`define SSR_OFF_DIV_LOW    8'h08
`define SSR_OFF_DIV_HIGH   8'h0c
`define SSR_OFF_TX_DATA    8'h10
`define SSR_OFF_TX_CTRL    8'h14
`define SSR_OFF_RX_DATA    8'h18
`define SSR_OFF_RX_STATUS  8'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SSR_BIT_RX_IDLE    6
`define SSR_BIT_CKP        4
`define SSR_BIT_PORT_EN    7
`define SSR_BIT_NINE_EN    6
`define SSR_BIT_SINGLE_EN  5
`define SSR_BIT_CONT_EN    4
`define SSR_BIT_OVERRUN    1
`define SSR_BIT_NINTH      0
`define SSR_BIT_CLK_SRC    7
`define SSR_BIT_SYNC       4
`define SSR_BIT_RCV_FLAG   0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SSR_RST_DIV_LOW    8'h07
`define SSR_RST_DIV_HIGH   8'h00
`define SSR_LAST_BIT_8     4'h7
`define SSR_LAST_BIT_9     4'h8
`define SSR_FIFO_FULL      2'h2
`define SSR_RESP_OKAY      2'h0
`define SSR_RESP_SLVERR    2'h2

`endif

/* File: inc/ssr_pkg.sv */
`include "ssr_defines.svh"

package ssr_pkg;

   // Master shift clock phases
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_ACT  = 2'b10
   } ssr_state_t;

   // One received character
   typedef struct packed {
      logic       ninth;
      logic [7:0] low;
   } ssr_char_t;

   // One register write from the bus
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } ssr_wr_t;

   // Mapped register check, used for both read and write answers
   function automatic logic ssr_hit(input logic [7:0] a);
      ssr_hit = (a[1:0] == 2'h0) && (a <= `SSR_OFF_RX_STATUS);
   endfunction

endpackage

/* File: rtl/ssr_axil_slave.sv */
`timescale 1ns/1ps
`include "ssr_defines.svh"

module ssr_axil_slave
   import ssr_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Write address and data
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output      logic        s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output      logic        s_wready,
   // Write response
   output      logic [1:0]  s_bresp,
   output      logic        s_bvalid,
   input  wire logic        s_bready,
   // Read address and data
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output      logic        s_arready,
   output      logic [31:0] s_rdata,
   output      logic [1:0]  s_rresp,
   output      logic        s_rvalid,
   input  wire logic        s_rready,
   // Register side
   output      ssr_wr_t     wr,
   output      logic        wr_en,
   output      logic        rd_en,
   output      logic [7:0]  rd_addr,
   input  wire logic [31:0] rd_word
);

   logic aw_full;
   logic w_full;

   // Address and data may arrive in either order
   always_ff @(posedge clk) begin
      if (rst) begin
         aw_full   <= 1'b0;
         w_full    <= 1'b0;
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         wr        <= '0;
      end else if (aw_full && w_full && !s_bvalid) begin
         aw_full <= 1'b0;
         w_full  <= 1'b0;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_full   <= 1'b1;
            s_awready <= 1'b0;
            wr.addr   <= s_awaddr;
         end else if (!aw_full && !s_bvalid) begin
            s_awready <= 1'b1;
         end
         if (s_wvalid && s_wready) begin
            w_full   <= 1'b1;
            s_wready <= 1'b0;
            wr.data  <= s_wdata;
            wr.strb  <= s_wstrb;
         end else if (!w_full && !s_bvalid) begin
            s_wready <= 1'b1;
         end
      end
   end

   // Write strobe and response once both halves are held
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_en    <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp  <= `SSR_RESP_OKAY;
      end else begin
         wr_en <= aw_full && w_full && !s_bvalid;
         if (aw_full && w_full && !s_bvalid) begin
            s_bvalid <= 1'b1;
            s_bresp  <= ssr_hit(wr.addr) ? `SSR_RESP_OKAY : `SSR_RESP_SLVERR;
         end else if (s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // Read data is captured before the pop strobe acts
   always_ff @(posedge clk) begin
      if (rst) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= '0;
         s_rresp   <= `SSR_RESP_OKAY;
         rd_en     <= 1'b0;
         rd_addr   <= '0;
      end else begin
         rd_en <= s_arvalid && s_arready;
         if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid  <= 1'b1;
            s_rdata   <= rd_word;
            s_rresp   <= ssr_hit(s_araddr) ? `SSR_RESP_OKAY : `SSR_RESP_SLVERR;
            rd_addr   <= s_araddr;
         end else begin
            if (s_rvalid && s_rready) begin
               s_rvalid <= 1'b0;
            end
            if (!s_rvalid) begin
               s_arready <= 1'b1;
            end
         end
      end
   end

endmodule

/* File: rtl/ssr_sync_receiver.sv */
`timescale 1ns/1ps
`include "ssr_defines.svh"

module ssr_sync_receiver
   import ssr_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // AXI4-Lite write channels
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output      logic        s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output      logic        s_wready,
   output      logic [1:0]  s_bresp,
   output      logic        s_bvalid,
   input  wire logic        s_bready,
   // AXI4-Lite read channels
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output      logic        s_arready,
   output      logic [31:0] s_rdata,
   output      logic [1:0]  s_rresp,
   output      logic        s_rvalid,
   input  wire logic        s_rready,
   // Shift clock pin
   input  wire logic        clock_pin_in,
   output      logic        clock_pin_out,
   output      logic        clock_pin_oe,
   // Data pin
   input  wire logic        data_pin_in,
   output      logic        data_pin_out,
   output      logic        data_pin_oe,
   // Status
   output      logic        receive_flag
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   ssr_wr_t     wr;
   logic        wr_en;
   logic        rd_en;
   logic [7:0]  rd_addr;
   logic [31:0] rd_word;
   logic        wr_lane;

   logic        serial_port_enable;
   logic        nine_bit_receive_enable;
   logic        single_receive_enable;
   logic        continuous_receive_enable;
   logic        clock_idle_polarity;
   logic        clock_source_master;
   logic        sync_mode;
   logic [15:0] baud_divisor;

   logic        overrun_flag;
   logic        overrun_cont;
   ssr_char_t   fifo_mem [0:1];
   logic        rd_ptr;
   logic        wr_ptr;
   logic [1:0]  fifo_cnt;
   logic        push;
   logic        pop;
   logic        overflow;
   logic        rx_read;

   logic [8:0]  receive_shift_register;
   logic [3:0]  bit_cnt;
   logic        last_bit;
   logic        rx_go;
   logic        trail;
   logic        char_done;
   ssr_char_t   next_char;

   ssr_state_t  ck_state;
   logic [15:0] ck_cnt;
   logic        mst_trail;
   logic        slv_trail;

   logic [1:0]  pin_raw;
   logic [2:0]  pin_sh [0:1];
   logic [1:0]  pin_lvl;
   logic [1:0]  pin_chg;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   ssr_axil_slave u_bus (
      .clk       (clk),
      .rst       (rst),
      .s_awaddr  (s_awaddr),
      .s_awvalid (s_awvalid),
      .s_awready (s_awready),
      .s_wdata   (s_wdata),
      .s_wstrb   (s_wstrb),
      .s_wvalid  (s_wvalid),
      .s_wready  (s_wready),
      .s_bresp   (s_bresp),
      .s_bvalid  (s_bvalid),
      .s_bready  (s_bready),
      .s_araddr  (s_araddr),
      .s_arvalid (s_arvalid),
      .s_arready (s_arready),
      .s_rdata   (s_rdata),
      .s_rresp   (s_rresp),
      .s_rvalid  (s_rvalid),
      .s_rready  (s_rready),
      .wr        (wr),
      .wr_en     (wr_en),
      .rd_en     (rd_en),
      .rd_addr   (rd_addr),
      .rd_word   (rd_word)
   );

   // Registers are one byte wide, so only the low lane writes
   assign wr_lane = wr_en && wr.strb[0];
   assign rx_read = rd_en && (rd_addr == `SSR_OFF_RX_DATA);

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   // Baud, polarity and clock source settings
   always_ff @(posedge clk) begin
      if (rst) begin
         clock_idle_polarity <= 1'b0;
         clock_source_master <= 1'b0;
         sync_mode           <= 1'b0;
         baud_divisor        <= {`SSR_RST_DIV_HIGH, `SSR_RST_DIV_LOW};
      end else if (wr_lane) begin
         unique case (wr.addr)
            `SSR_OFF_BAUD_CTRL: clock_idle_polarity <= wr.data[`SSR_BIT_CKP];
            `SSR_OFF_TX_CTRL: begin
               clock_source_master <= wr.data[`SSR_BIT_CLK_SRC];
               sync_mode           <= wr.data[`SSR_BIT_SYNC];
            end
            `SSR_OFF_DIV_LOW:  baud_divisor[7:0]  <= wr.data[7:0];
            `SSR_OFF_DIV_HIGH: baud_divisor[15:8] <= wr.data[7:0];
            default: ;
         endcase
      end
   end

   // Receive control; a software write wins over the hardware clear
   always_ff @(posedge clk) begin
      if (rst) begin
         serial_port_enable        <= 1'b0;
         nine_bit_receive_enable   <= 1'b0;
         single_receive_enable     <= 1'b0;
         continuous_receive_enable <= 1'b0;
      end else if (wr_lane && (wr.addr == `SSR_OFF_RX_CTRL)) begin
         serial_port_enable        <= wr.data[`SSR_BIT_PORT_EN];
         nine_bit_receive_enable   <= wr.data[`SSR_BIT_NINE_EN];
         single_receive_enable     <= wr.data[`SSR_BIT_SINGLE_EN];
         continuous_receive_enable <= wr.data[`SSR_BIT_CONT_EN];
      end else if (char_done) begin
         single_receive_enable <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   assign pin_raw = {data_pin_in, clock_pin_in};

   // Three stages; a level counts once stages two and three agree
   for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge clk) begin
         if (rst) begin
            pin_sh[i]  <= 3'h0;
            pin_lvl[i] <= 1'b0;
         end else begin
            pin_sh[i] <= {pin_sh[i][1:0], pin_raw[i]};
            if (pin_chg[i]) begin
               pin_lvl[i] <= pin_sh[i][2];
            end
         end
      end
      assign pin_chg[i] = (pin_sh[i][1] == pin_sh[i][2]) && (pin_sh[i][2] != pin_lvl[i]);
   end

   // ----------------------------------------------------------------
   // Trailing edge detection
   // ----------------------------------------------------------------
   // Nothing shifts unless an enable is set and no overrun stands
   assign rx_go = serial_port_enable && sync_mode && !overrun_flag &&
                  (single_receive_enable || continuous_receive_enable);

   // Slave: a change back to the idle level is the trailing edge
   assign slv_trail = !clock_source_master && pin_chg[0] &&
                      (pin_sh[0][2] == clock_idle_polarity);

   // Master: leaving the active half is the trailing edge
   assign mst_trail = (ck_state == ST_ACT) && (ck_cnt == 16'h0000);

   assign trail     = rx_go && (clock_source_master ? mst_trail : slv_trail);
   assign last_bit  = bit_cnt == (nine_bit_receive_enable ? `SSR_LAST_BIT_9 : `SSR_LAST_BIT_8);
   assign char_done = trail && last_bit;

   // ----------------------------------------------------------------
   // Master clock generator
   // ----------------------------------------------------------------
   // Each half period lasts baud_divisor plus one clocks; dropping an
   // enable returns the pin to idle at once mid-character
   always_ff @(posedge clk) begin
      if (rst || !(rx_go && clock_source_master)) begin
         ck_state <= ST_IDLE;
         ck_cnt   <= 16'h0000;
      end else begin
         unique case (ck_state)
            ST_IDLE: begin
               ck_state <= ST_WAIT;
               ck_cnt   <= baud_divisor;
            end
            ST_WAIT: begin
               if (ck_cnt == 16'h0000) begin
                  ck_state <= ST_ACT;
                  ck_cnt   <= baud_divisor;
               end else begin
                  ck_cnt <= ck_cnt - 16'h0001;
               end
            end
            ST_ACT: begin
               if (ck_cnt == 16'h0000) begin
                  ck_state <= ST_WAIT;
                  ck_cnt   <= baud_divisor;
               end else begin
                  ck_cnt <= ck_cnt - 16'h0001;
               end
            end
            default: begin
               ck_state <= ST_IDLE;
               ck_cnt   <= 16'h0000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Receive shifter
   // ----------------------------------------------------------------
   // Least significant bit arrives first
   always_comb begin
      next_char = receive_shift_register;
      next_char[bit_cnt] = pin_lvl[1];
      if (!nine_bit_receive_enable) begin
         next_char.ninth = 1'b0;
      end
   end

   // Losing the enable drops the partial character
   always_ff @(posedge clk) begin
      if (rst || !rx_go) begin
         bit_cnt <= 4'h0;
      end else if (trail) begin
         receive_shift_register <= next_char;
         bit_cnt <= last_bit ? 4'h0 : bit_cnt + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // Receive FIFO and overrun
   // ----------------------------------------------------------------
   // A pop in the same cycle makes room for the arriving character
   assign pop      = rx_read && (fifo_cnt != 2'h0);
   assign push     = char_done && ((fifo_cnt != `SSR_FIFO_FULL) || pop);
   assign overflow = char_done && (fifo_cnt == `SSR_FIFO_FULL) && !pop;

   // Storage is not reset; only the pointers say what is valid
   always_ff @(posedge clk) begin
      if (push) begin
         fifo_mem[wr_ptr] <= next_char;
      end
   end

   // Clearing the port enable flushes the whole receiver
   always_ff @(posedge clk) begin
      if (rst || !serial_port_enable) begin
         rd_ptr   <= 1'b0;
         wr_ptr   <= 1'b0;
         fifo_cnt <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
      end
   end

   // Overrun remembers which mode it arose in, since that picks its clear
   always_ff @(posedge clk) begin
      if (rst || !serial_port_enable) begin
         overrun_flag <= 1'b0;
         overrun_cont <= 1'b0;
      end else if (overflow) begin
         overrun_flag <= 1'b1;
         overrun_cont <= continuous_receive_enable;
      end else if (overrun_flag) begin
         if (overrun_cont ? !continuous_receive_enable : rx_read) begin
            overrun_flag <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register read mux
   // ----------------------------------------------------------------
   // Sampled by the slave at the address handshake, before any pop
   always_comb begin
      logic [7:0] b;
      b = 8'h00;
      unique case (s_araddr)
         `SSR_OFF_BAUD_CTRL: begin
            b[`SSR_BIT_RX_IDLE] = bit_cnt == 4'h0;
            b[`SSR_BIT_CKP]     = clock_idle_polarity;
         end
         `SSR_OFF_RX_CTRL: begin
            b[`SSR_BIT_PORT_EN]   = serial_port_enable;
            b[`SSR_BIT_NINE_EN]   = nine_bit_receive_enable;
            b[`SSR_BIT_SINGLE_EN] = single_receive_enable;
            b[`SSR_BIT_CONT_EN]   = continuous_receive_enable;
            b[`SSR_BIT_OVERRUN]   = overrun_flag;
            b[`SSR_BIT_NINTH]     = (fifo_cnt != 2'h0) && fifo_mem[rd_ptr].ninth;
         end
         `SSR_OFF_DIV_LOW:  b = baud_divisor[7:0];
         `SSR_OFF_DIV_HIGH: b = baud_divisor[15:8];
         `SSR_OFF_TX_CTRL: begin
            b[`SSR_BIT_CLK_SRC] = clock_source_master;
            b[`SSR_BIT_SYNC]    = sync_mode;
         end
         `SSR_OFF_RX_DATA: begin
            if (fifo_cnt != 2'h0) begin
               b = fifo_mem[rd_ptr].low;
            end
         end
         `SSR_OFF_RX_STATUS: begin
            b[`SSR_BIT_RCV_FLAG] = fifo_cnt != 2'h0;
            b[2:1]               = fifo_cnt;
         end
         default: b = 8'h00;
      endcase
      rd_word = {24'h000000, b};
   end

   // ----------------------------------------------------------------
   // Pin drivers and status
   // ----------------------------------------------------------------
   // Clock driver on only as master; the data pin is never driven
   // because this block only receives
   always_ff @(posedge clk) begin
      if (rst) begin
         clock_pin_out <= 1'b0;
         clock_pin_oe  <= 1'b0;
         data_pin_out  <= 1'b0;
         data_pin_oe   <= 1'b0;
      end else begin
         clock_pin_out <= (ck_state == ST_ACT) ^ clock_idle_polarity;
         clock_pin_oe  <= serial_port_enable && clock_source_master;
         data_pin_out  <= 1'b0;
         data_pin_oe   <= 1'b0;
      end
   end

   // Flag follows FIFO occupancy one cycle late
   always_ff @(posedge clk) begin
      if (rst) begin
         receive_flag <= 1'b0;
      end else begin
         receive_flag <= fifo_cnt != 2'h0;
      end
   end

endmodule

/* File: sim/ssr_sync_receiver_assertions.sv */
`timescale 1ns/1ps

module ssr_sync_receiver_assertions (
   // Clock, reset, bus
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        s_awready,
   input wire logic        s_wready,
   input wire logic        s_bvalid,
   input wire logic        s_bready,
   input wire logic        s_arvalid,
   input wire logic        s_arready,
   input wire logic [31:0] s_rdata,
   input wire logic        s_rvalid,
   input wire logic        s_rready,
   // Pins, status
   input wire logic        data_pin_oe,
   input wire logic        receive_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ---------------------------
   // Bus and pin checks
   // ---------------------------
   sequence s_rd_taken; s_arvalid && s_arready; endsequence
   sequence s_wr_done; s_bvalid && s_bready; endsequence
   property p_rd_answer; s_rd_taken |=> s_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_rd_hold; s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
   property p_wr_hold; s_bvalid && !s_bready |=> s_bvalid; endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
   property p_wr_done; s_wr_done |=> !s_bvalid; endproperty
   a_wr_done: assert property (p_wr_done) else $error("write answer stuck");
   property p_rd_refuse; s_rvalid |-> !s_arready; endproperty
   a_rd_refuse: assert property (p_rd_refuse) else $error("read taken early");
   property p_wr_refuse; s_bvalid |-> !s_awready && !s_wready; endproperty
   a_wr_refuse: assert property (p_wr_refuse) else $error("write taken early");
   property p_rd_upper; s_rvalid |-> s_rdata[31:8] == 24'h0; endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
   property p_data_off; !data_pin_oe; endproperty
   a_data_off: assert property (p_data_off) else $error("data pin driven");
   // Reset leaves the block quiet
   property p_rst;
      disable iff (1'b0) rst |=> !s_awready && !s_arready && !s_rvalid && !receive_flag;
   endproperty
   a_rst: assert property (p_rst) else $error("not quiet after reset");
endmodule

bind ssr_sync_receiver ssr_sync_receiver_assertions chk (.clk(clk), .rst(rst),
   .s_awready(s_awready), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_bready(s_bready),
   .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid),
   .s_rready(s_rready), .data_pin_oe(data_pin_oe), .receive_flag(receive_flag));

/* File: sim/ssr_link_partner.sv */
`timescale 1ns/1ps

module ssr_link_partner (
   // Clock pin seen from outside
   input  wire logic clk,
   input  wire logic ck_wire,
   input  wire logic ck_oe,
   input  wire logic idle,
   // Driven levels
   output      logic ck,
   output      logic dt
);
   logic [31:0] bits;
   logic        prev, act;
   int          n_lead;
   initial {bits, prev, act, dt, n_lead} = 0;
   assign ck = idle ^ act; // Parks at idle level between frames
   // Next bit goes out on each leading edge of the device clock
   always @(posedge clk) begin
      prev <= ck_wire;
      if (ck_oe && prev == idle && ck_wire != idle) begin
         dt     <= bits[0];
         bits   <= bits >> 1;
         n_lead <= n_lead + 1;
      end
   end
   // Slave frame: one pulse per bit, odd phase to the system clock
   task automatic send(input logic [8:0] v, input int nb);
      #7;
      for (int i = 0; i < nb; i++) begin
         act = 1'b1;
         dt  = v[i];
         #200;
         act = 1'b0;
         #200;
      end
      dt = ~dt; // Released line, stale value hidden
   endtask
endmodule

/* File: sim/ssr_sync_receiver_test.sv */
`timescale 1ns/1ps

module ssr_sync_receiver_test;
   logic        clk, rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, pol;
   logic [7:0]  s_awaddr, s_araddr;
   logic [31:0] s_wdata, d;
   logic [3:0]  s_wstrb;
   logic [1:0]  r;
   logic [8:0]  c0, c1, c2;
   wire         s_awready, s_wready, s_bvalid, s_arready, s_rvalid, receive_flag, sck, sdt;
   wire         clock_pin_out, clock_pin_oe, data_pin_out, data_pin_oe;
   wire  [1:0]  s_bresp, s_rresp;
   wire  [31:0] s_rdata;
   wire         clock_pin_in = clock_pin_oe ? clock_pin_out : sck;
   wire         data_pin_in  = data_pin_oe ? data_pin_out : sdt; // Digital pin
   int          n_mismatch, tests_run, t;

   ssr_sync_receiver dut (.*);
   ssr_link_partner link (.clk(clk), .ck_wire(clock_pin_in), .ck_oe(clock_pin_oe),
      .idle(pol), .ck(sck), .dt(sdt));

   // ---------------------------
   // Bus tasks and checks
   // ---------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      s_awaddr  <= a;
      s_wdata   <= {24'h0, v};
      s_awvalid <= 1'b1;
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      for (t = 0; t < 99 && !s_bvalid; t++) begin
         @(posedge clk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end
      s_bready <= 1'b0;
      r = s_bresp;
      if (!s_bvalid) n_mismatch++;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      for (t = 0; t < 99 && !s_rvalid; t++) begin
         @(posedge clk);
         if (s_arready) s_arvalid <= 1'b0;
      end
      s_rready <= 1'b0;
      d = s_rdata;
      r = s_rresp;
      if (!s_rvalid) n_mismatch++;
   endtask
   task automatic wait_flag;
      for (t = 0; t < 3000 && receive_flag !== 1'b1; t++) @(posedge clk);
      chk(32'(receive_flag), 1);
   endtask
   // Expected receive control word: enables, overrun, ninth bit
   function automatic logic [31:0] exp_ctrl(input logic [7:0] en, input logic ovr, input logic ninth);
      return {24'h0, en[7:2], ovr, ninth};
   endfunction
   task automatic conclude;
      if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   // Hang guard, well past the longest receive sequence
   initial begin
      #3000000;
      n_mismatch++;
      conclude();
   end
   // ---------------------------
   // Scenarios
   // ---------------------------
   initial begin
      {rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, pol} = 7'h40;
      {s_awaddr, s_araddr, s_wdata} = 48'h0;
      s_wstrb = 4'hf;
      n_mismatch = 0;
      tests_run = 0;
      t = $urandom(32'hb8b718f8);
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(8'h08); chk(d, 32'h7);
      rd(8'h20); chk(32'(r), 32'h2);
      wr(8'h20, 8'hff); chk(32'(r), 32'h2);
      wr(8'h14, 8'h90); chk(32'(r), 32'h0);
      // Single master receive at both clock polarities
      for (int p = 0; p < 2; p++) begin
         pol <= p[0];
         wr(8'h00, {3'h0, p[0], 4'h0});
         c0 = 9'($urandom);
         link.bits <= 32'(c0[7:0]);
         link.n_lead <= 0;
         wr(8'h04, 8'ha0);
         chk(32'({data_pin_oe, data_pin_out}), 0);
         wait_flag();
         chk(32'(link.n_lead), 8);
         chk(32'(clock_pin_out), 32'(p));
         chk(32'(clock_pin_oe), 1);
         rd(8'h04); chk(d, 32'h80);
         rd(8'h18); chk(d, 32'(c0[7:0]));
         repeat (2) @(posedge clk);
         chk(32'(receive_flag), 0);
      end
      // Three single characters unread, overrun cleared by one data read
      c0 = 9'($urandom);
      c1 = 9'($urandom);
      for (int k = 0; k < 3; k++) begin
         link.bits <= 32'(k == 0 ? c0[7:0] : c1[7:0]);
         wr(8'h04, 8'ha0);
         d = 32'h20;
         for (int i = 0; i < 200 && d[5]; i++) rd(8'h04);
      end
      chk(d, exp_ctrl(8'h80, 1'b1, 1'b0));
      rd(8'h18); chk(d, 32'(c0[7:0]));
      rd(8'h04); chk(d, exp_ctrl(8'h80, 1'b0, 1'b0));
      rd(8'h18); chk(d, 32'(c1[7:0]));
      // Nine-bit continuous stream into overrun
      c0 = 9'($urandom);
      c1 = 9'($urandom);
      c2 = 9'($urandom);
      link.bits <= {5'h0, c2, c1, c0};
      wr(8'h04, 8'hd0);
      d = 32'h0;
      for (int i = 0; i < 200 && d[1] !== 1'b1; i++) rd(8'h04);
      chk(d, exp_ctrl(8'hd0, 1'b1, c0[8]));
      rd(8'h18); chk(d, 32'(c0[7:0]));
      rd(8'h04); chk(d, exp_ctrl(8'hd0, 1'b1, c1[8]));
      rd(8'h18); chk(d, 32'(c1[7:0]));
      wr(8'h04, 8'h80);
      rd(8'h04); chk(d, 32'h80);
      rd(8'h1c); chk(d, 32'h0);
      // Both enables, then continuous cut a few bits into the next character
      c0 = 9'($urandom);
      link.bits <= 32'(c0[7:0]);
      wr(8'h04, 8'hb0);
      wait_flag();
      rd(8'h04); chk(d, 32'h90);
      repeat (40) @(posedge clk);
      wr(8'h04, 8'h80);
      rd(8'h1c); chk(d, 32'h3);
      rd(8'h00); chk(d, 32'h50);
      chk(32'(clock_pin_out), 1);
      rd(8'h18); chk(d, 32'(c0[7:0]));
      // Slave receive on the external link clock
      wr(8'h14, 8'h10);
      c0 = 9'($urandom);
      wr(8'h04, 8'ha0);
      link.send(c0, 8);
      wait_flag();
      chk(32'(clock_pin_oe), 0);
      rd(8'h18); chk(d, 32'(c0[7:0]));
      conclude();
   end
endmodule
